// ### src/plu_regs.vh
/*
  Register offsets, field positions, reset values and timing counts
  for the parallel line unit.
  Assumes a 40 MHz core clock and a 16-bit host address whose low
  three bits pick a register.
*/
`ifndef PLU_REGS_VH
`define PLU_REGS_VH

// ----------------------------------------------------------------
// register offsets (address bits 2:0)
// ----------------------------------------------------------------
`define PLU_OFF_CSR 3'h0
`define PLU_OFF_OUT 3'h2
`define PLU_OFF_IN 3'h4
`define PLU_OFF_NONE 3'h6

// ----------------------------------------------------------------
// control/status word fields
// ----------------------------------------------------------------
`define PLU_CSR_REQ_B 15
`define PLU_CSR_REQ_A 7
`define PLU_CSR_IE_A 6
`define PLU_CSR_IE_B 5
`define PLU_CSR_CMD_1 1
`define PLU_CSR_CMD_0 0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PLU_OUT_RESET 16'h0000
`define PLU_CSR_RESET 1'b0

// ----------------------------------------------------------------
// factory jumper pattern: word 167770 octal, vectors 300 and 304 octal
// ----------------------------------------------------------------
`define PLU_DEF_ADDR 16'hEFF8
`define PLU_DEF_ADDR_JMP 10'h1FF
`define PLU_DEF_VEC_A 8'hC0
`define PLU_DEF_VEC_B 8'hC4
`define PLU_DEF_VEC_JMP 5'h18
`define PLU_VEC_LOW_A 3'h0
`define PLU_VEC_LOW_B 3'h4

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PLU_CLK_NS 25
`define PLU_PULSE_NS 300
`define PLU_PULSE_CYC ((`PLU_PULSE_NS + `PLU_CLK_NS - 1) / `PLU_CLK_NS)
`define PLU_PULSE_W 5

`endif

// ### src/plu_pulse.v
/*
  One-shot that turns a one-cycle trigger into a fixed-width
  positive pulse.
  Assumes trigger and reset are on the core clock.
*/
`include "plu_regs.vh"

module plu_pulse (
  input wire clk,
  input wire rst_n,
  input wire trig,
  output reg pulse
);

  reg [`PLU_PULSE_W-1:0] count;
  localparam integer load_count = `PLU_PULSE_CYC - 1;

  // ----------------------------------------------------------------
  // width counter
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      count <= {`PLU_PULSE_W{1'b0}};
      pulse <= 1'b0;
    end else if (trig) begin
      count <= load_count[`PLU_PULSE_W-1:0];
      pulse <= 1'b1;
    end else if (count != {`PLU_PULSE_W{1'b0}}) begin
      count <= count - 1'b1;
    end else begin
      pulse <= 1'b0;
    end
  end

endmodule // plu_pulse

// ### src/plu_fifo.v
/*
  Two-entry buffer with valid/ready on both sides.
  Assumes a single clock; pushes while full are refused by in_ready.
*/
module plu_fifo #(
  parameter WIDTH = 16
) (
  input wire clk,
  input wire rst_n,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem [0:1];
  reg wr_ptr;
  reg rd_ptr;
  reg [1:0] count;
  wire push;
  wire pop;

  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // ----------------------------------------------------------------
  // storage and pointers
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      if (push & ~pop) begin
        count <= count + 2'h1;
      end else if (pop & ~push) begin
        count <= count - 2'h1;
      end
    end
  end

endmodule // plu_fifo

// ### src/plu_top.v
/*
  Parallel line unit: host bus slave with output latch, input gate,
  control/status word, two request flags and vectored interrupts.
  Assumes an asynchronous multiplexed host bus whose strobes and data
  lines are sampled through two flops; open-drain lines are given as
  output enables that pull the line low.
*/
// Operation
// - sixteen input lines and sixteen latched output lines face the user.
// - address bits 3 to 12 come from jumpers; removed gives one.
// - vector bits 3 to 7 come from jumpers; removed gives one.
// - factory jumpers give word 167770 and vectors 300, 304 octal.
// - the output latch is written and read back by the host.
// - each output latch write fires a positive 300 ns strobe.
// - input reads gate the live input lines onto the bus.
// - after an input read, a positive 300 ns acknowledge pulse.
// - request B reads in bit 15, request A in bit 7.
// - enable A bit 6 with request A interrupts; B with bit 5.
// - both enables are set and cleared by host writes.
// - with both pending, interrupt A is serviced first.
// - bus initialize clears latch, bits 6,5,1,0 and request flops.
// - bus initialize is forwarded high on both user connectors.
// - offsets 0, 2, 4 pick status, latch, input; 6 gets no reply.
// - vector low bits are 0 for A and 4 for B.
// - bits 1 and 0 are host command bits driven to the user.
`include "plu_regs.vh"

module plu_top (
  input wire CORE_CLK,
  input wire RST_N,
  input wire BUS_INIT_N,
  input wire [15:0] BDAL_IN,
  output reg [15:0] BDAL_OUT,
  output reg BDAL_OE,
  input wire BSYNC_N,
  input wire BDIN_N,
  input wire BDOUT_N,
  input wire BBS7_N,
  input wire BIAKI_N,
  output reg BIAKO_N,
  output reg BRPLY_OE,
  output wire BIRQ_OE,
  input wire [9:0] ADDR_JUMPER,
  input wire [4:0] VEC_JUMPER,
  input wire [15:0] USER_IN,
  output wire [15:0] USER_OUT,
  output wire OUT_STROBE,
  output wire READ_ACK_PULSE,
  input wire USER_REQ_A,
  input wire USER_REQ_B,
  output reg USER_CMD_0,
  output reg USER_CMD_1,
  output reg USER_RESET_OUT_A,
  output reg USER_RESET_OUT_B
);

  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_READ = 3'h2;
  localparam ST_WRITE = 3'h3;
  localparam ST_REPLY = 3'h4;
  localparam ST_IACK = 3'h5;
  localparam ST_SKIP = 3'h6;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  reg [15:0] dal_m;
  reg [15:0] dal_s;
  reg [15:0] uin_m;
  reg [15:0] uin_s;
  reg [6:0] ctl_m;
  reg [6:0] ctl_s;
  reg [1:0] req_m;
  reg [1:0] req_s;
  reg [14:0] jmp_m;
  reg [14:0] jmp_s;

  always @(posedge CORE_CLK) begin
    dal_m <= BDAL_IN;
    dal_s <= dal_m;
    uin_m <= USER_IN;
    uin_s <= uin_m;
    ctl_m <= {BUS_INIT_N, BSYNC_N, BDIN_N, BDOUT_N, BBS7_N, BIAKI_N, 1'b0};
    ctl_s <= ctl_m;
    req_m <= {USER_REQ_B, USER_REQ_A};
    req_s <= req_m;
    jmp_m <= {ADDR_JUMPER, VEC_JUMPER};
    jmp_s <= jmp_m;
  end

  wire init_act = ~ctl_s[6];
  wire sync_act = ~ctl_s[5];
  wire din_act = ~ctl_s[4];
  wire dout_act = ~ctl_s[3];
  wire bs7_act = ~ctl_s[2];
  wire iak_act = ~ctl_s[1];
  wire req_a = req_s[0];
  wire req_b = req_s[1];
  wire [9:0] addr_jmp = jmp_s[14:5];
  wire [4:0] vec_jmp = jmp_s[4:0];
  wire rst_int_n = RST_N & ~init_act;

  // ----------------------------------------------------------------
  // initialize forwarding
  // ----------------------------------------------------------------
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      USER_RESET_OUT_A <= 1'b0;
      USER_RESET_OUT_B <= 1'b0;
    end else begin
      USER_RESET_OUT_A <= init_act;
      USER_RESET_OUT_B <= init_act;
    end
  end

  // ----------------------------------------------------------------
  // state and registers
  // ----------------------------------------------------------------
  reg [2:0] state;
  reg [2:0] reg_sel;
  reg [15:0] output_latch_word;
  reg irq_enable_a;
  reg irq_enable_b;
  reg irq_flop_a;
  reg irq_flop_b;
  reg arm_a;
  reg arm_b;
  reg iak_src_b;
  reg push_req;
  reg ack_trig;
  wire fifo_ready;
  wire fifo_valid;
  wire [15:0] fifo_data;
  wire fifo_pop;

  wire [15:0] control_status_word = {req_b, 7'h00, req_a, irq_enable_a, irq_enable_b, 3'h0,
                                     USER_CMD_1, USER_CMD_0};
  wire [15:0] input_gate_word = uin_s;

  wire addr_hit = bs7_act & (dal_s[12:3] == addr_jmp) & (dal_s[2:0] != `PLU_OFF_NONE);

  // ----------------------------------------------------------------
  // output word buffer and strobe
  // ----------------------------------------------------------------
  // the next word waits while a strobe runs, so the user never sees
  // data change under a strobe; with two words waiting, the next write stalls the bus reply
  wire strobe_busy = OUT_STROBE;
  reg strobe_trig;

  plu_fifo #(
    .WIDTH(16)
  ) u_fifo (
    .clk(CORE_CLK),
    .rst_n(rst_int_n),
    .in_valid(push_req),
    .in_ready(fifo_ready),
    .in_data(dal_s),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  assign fifo_pop = fifo_valid & ~strobe_busy & ~strobe_trig;

  always @(posedge CORE_CLK) begin
    if (!rst_int_n) begin
      output_latch_word <= `PLU_OUT_RESET;
      strobe_trig <= 1'b0;
    end else begin
      strobe_trig <= fifo_pop;
      if (fifo_pop) begin
        output_latch_word <= fifo_data;
      end
    end
  end

  assign USER_OUT = output_latch_word;

  plu_pulse u_strobe (
    .clk(CORE_CLK),
    .rst_n(rst_int_n),
    .trig(strobe_trig),
    .pulse(OUT_STROBE)
  );

  plu_pulse u_ack (
    .clk(CORE_CLK),
    .rst_n(rst_int_n),
    .trig(ack_trig),
    .pulse(READ_ACK_PULSE)
  );

  // ----------------------------------------------------------------
  // interrupt request flops
  // ----------------------------------------------------------------
  wire want_a = req_a & irq_enable_a;
  wire want_b = req_b & irq_enable_b;
  wire clr_a = (state == ST_IACK) & ~iak_src_b & ~din_act;
  wire clr_b = (state == ST_IACK) & iak_src_b & ~din_act;

  always @(posedge CORE_CLK) begin
    if (!rst_int_n) begin
      irq_flop_a <= 1'b0;
      irq_flop_b <= 1'b0;
      arm_a <= 1'b0;
      arm_b <= 1'b0;
    end else begin
      arm_a <= want_a;
      arm_b <= want_b;
      if (want_a & ~arm_a) begin
        irq_flop_a <= 1'b1;
      end else if (clr_a | ~irq_enable_a) begin
        irq_flop_a <= 1'b0;
      end
      if (want_b & ~arm_b) begin
        irq_flop_b <= 1'b1;
      end else if (clr_b | ~irq_enable_b) begin
        irq_flop_b <= 1'b0;
      end
    end
  end

  assign BIRQ_OE = irq_flop_a | irq_flop_b;

  // ----------------------------------------------------------------
  // bus cycle machine
  // ----------------------------------------------------------------
  always @(posedge CORE_CLK) begin
    if (!rst_int_n) begin
      state <= ST_IDLE;
      reg_sel <= 3'h0;
      BDAL_OUT <= 16'h0000;
      BDAL_OE <= 1'b0;
      BRPLY_OE <= 1'b0;
      BIAKO_N <= 1'b1;
      irq_enable_a <= `PLU_CSR_RESET;
      irq_enable_b <= `PLU_CSR_RESET;
      USER_CMD_0 <= `PLU_CSR_RESET;
      USER_CMD_1 <= `PLU_CSR_RESET;
      iak_src_b <= 1'b0;
      push_req <= 1'b0;
      ack_trig <= 1'b0;
    end else begin
      push_req <= 1'b0;
      ack_trig <= 1'b0;
      case (state)
        ST_IDLE: begin
          BIAKO_N <= 1'b1;
          if (iak_act & din_act) begin
            if (BIRQ_OE) begin
              iak_src_b <= ~irq_flop_a;
              BDAL_OUT <= {8'h00, vec_jmp,
                           irq_flop_a ? `PLU_VEC_LOW_A : `PLU_VEC_LOW_B};
              BDAL_OE <= 1'b1;
              state <= ST_IACK;
            end else begin
              BIAKO_N <= 1'b0;
              state <= ST_SKIP;
            end
          end else if (sync_act & ~din_act & ~dout_act) begin
            if (addr_hit) begin
              reg_sel <= dal_s[2:0];
              state <= ST_ADDR;
            end else begin
              state <= ST_SKIP;
            end
          end
        end
        ST_ADDR: begin
          if (!sync_act) begin
            state <= ST_IDLE;
          end else if (din_act) begin
            state <= ST_READ;
          end else if (dout_act) begin
            state <= ST_WRITE;
          end
        end
        ST_READ: begin
          // latch reads wait until buffered words reach the pins
          if ((reg_sel != `PLU_OFF_OUT) | ~fifo_valid) begin
            case (reg_sel)
              `PLU_OFF_CSR: BDAL_OUT <= control_status_word;
              `PLU_OFF_OUT: BDAL_OUT <= output_latch_word;
              default: BDAL_OUT <= input_gate_word;
            endcase
            ack_trig <= (reg_sel == `PLU_OFF_IN);
            BDAL_OE <= 1'b1;
            state <= ST_REPLY;
          end
        end
        ST_WRITE: begin
          if (reg_sel == `PLU_OFF_CSR) begin
            irq_enable_a <= dal_s[`PLU_CSR_IE_A];
            irq_enable_b <= dal_s[`PLU_CSR_IE_B];
            USER_CMD_0 <= dal_s[`PLU_CSR_CMD_0];
            USER_CMD_1 <= dal_s[`PLU_CSR_CMD_1];
            state <= ST_REPLY;
          end else if (reg_sel == `PLU_OFF_OUT) begin
            // a full buffer holds the reply back
            if (fifo_ready) begin
              push_req <= 1'b1;
              state <= ST_REPLY;
            end
          end else begin
            state <= ST_REPLY;
          end
        end
        ST_REPLY: begin
          BRPLY_OE <= din_act | dout_act;
          if (!din_act & !dout_act & BRPLY_OE) begin
            BRPLY_OE <= 1'b0;
            BDAL_OE <= 1'b0;
            state <= sync_act ? ST_SKIP : ST_IDLE;
          end
        end
        ST_IACK: begin
          BRPLY_OE <= din_act;
          if (!din_act) begin
            BRPLY_OE <= 1'b0;
            BDAL_OE <= 1'b0;
            state <= ST_SKIP;
          end
        end
        ST_SKIP: begin
          // wait out a cycle that is not ours or has ended
          BIAKO_N <= ~(iak_act & ~BIAKO_N);
          if (!sync_act & !din_act & !dout_act & !iak_act) begin
            BIAKO_N <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // plu_top

// ### sim/plu_chk_asserts.sv
/* port checker for the parallel line unit top.
   assumes one core clock and a synchronous active-low reset. */
`include "plu_regs.vh"

module plu_chk (
  input wire CORE_CLK,
  input wire RST_N,
  input wire BUS_INIT_N,
  input wire [15:0] BDAL_OUT,
  input wire BDAL_OE,
  input wire BDIN_N,
  input wire BDOUT_N,
  input wire BIAKI_N,
  input wire BIAKO_N,
  input wire BRPLY_OE,
  input wire BIRQ_OE,
  input wire [4:0] VEC_JUMPER,
  input wire [15:0] USER_OUT,
  input wire OUT_STROBE,
  input wire READ_ACK_PULSE,
  input wire USER_REQ_A,
  input wire USER_REQ_B,
  input wire USER_CMD_0,
  input wire USER_CMD_1,
  input wire USER_RESET_OUT_A,
  input wire USER_RESET_OUT_B
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----
  // pulse counters: widths above 8 cycles are counted, not repeated
  // ----
  logic [4:0] cnt_s;
  logic [4:0] cnt_a;
  wire strb = !BDIN_N || !BDOUT_N;
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      cnt_s <= 5'h00;
      cnt_a <= 5'h00;
    end else begin
      cnt_s <= OUT_STROBE ? cnt_s + 5'h01 : 5'h00;
      cnt_a <= READ_ACK_PULSE ? cnt_a + 5'h01 : 5'h00;
    end
  end
  default clocking dcb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  a_strobe_width: assert property ($fell(OUT_STROBE) |-> cnt_s == `PLU_PULSE_CYC)
    else $error("strobe width wrong");
  a_ack_width: assert property ($fell(READ_ACK_PULSE) |-> cnt_a == `PLU_PULSE_CYC)
    else $error("ack width wrong");
  a_data_steady: assert property (OUT_STROBE |-> $stable(USER_OUT))
    else $error("output word moved under strobe");
  a_reply_cause: assert property ($rose(BRPLY_OE) |-> strb && $past(strb, 2))
    else $error("reply without strobe");
  a_reply_release: assert property ((!strb) [*6] |-> !BRPLY_OE && !BDAL_OE)
    else $error("reply held after strobe");
  a_read_drive: assert property ($rose(BDAL_OE) |-> !BDIN_N && BDOUT_N)
    else $error("bus driven outside a read");
  a_irq_cause: assert property ($rose(BIRQ_OE) |-> USER_REQ_A || USER_REQ_B)
    else $error("interrupt without request");
  a_init_clear: assert property ((!BUS_INIT_N) [*6] |-> USER_OUT == 16'h0000 && !USER_CMD_0 && !USER_CMD_1 && !BIRQ_OE)
    else $error("init left state set");
  a_init_fwd: assert property ((!BUS_INIT_N) [*6] |-> USER_RESET_OUT_A && USER_RESET_OUT_B)
    else $error("init not forwarded");
  a_fwd_idle: assert property (BUS_INIT_N [*6] |-> !USER_RESET_OUT_A && !USER_RESET_OUT_B)
    else $error("init output stuck high");
  a_vector_form: assert property (BRPLY_OE && BDAL_OE && !BIAKI_N |-> BDAL_OUT[15:8] == 8'h00 && BDAL_OUT[7:3] == VEC_JUMPER && BDAL_OUT[1:0] == 2'h0)
    else $error("vector malformed");
  a_pass_idle: assert property (BIAKI_N [*4] |-> BIAKO_N)
    else $error("grant passed without grant in");
  c_strobe: cover property ($fell(OUT_STROBE));
  c_ack: cover property ($fell(READ_ACK_PULSE));
  c_vector: cover property (BRPLY_OE && !BIAKI_N);
endmodule // plu_chk

bind plu_top plu_chk plu_chk_i (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .BUS_INIT_N(BUS_INIT_N), .BDAL_OUT(BDAL_OUT),
  .BDAL_OE(BDAL_OE), .BDIN_N(BDIN_N), .BDOUT_N(BDOUT_N), .BIAKI_N(BIAKI_N), .BIAKO_N(BIAKO_N), .BRPLY_OE(BRPLY_OE),
  .BIRQ_OE(BIRQ_OE), .VEC_JUMPER(VEC_JUMPER), .USER_OUT(USER_OUT), .OUT_STROBE(OUT_STROBE),
  .READ_ACK_PULSE(READ_ACK_PULSE), .USER_REQ_A(USER_REQ_A), .USER_REQ_B(USER_REQ_B), .USER_CMD_0(USER_CMD_0),
  .USER_CMD_1(USER_CMD_1), .USER_RESET_OUT_A(USER_RESET_OUT_A), .USER_RESET_OUT_B(USER_RESET_OUT_B));

// ### sim/plu_user_dev.sv
/* model of the user's parallel device on the far side.
   assumes strobe and acknowledge are registered on clk. */
module plu_user (
  input wire logic clk,
  input wire logic [15:0] out_word,
  input wire logic strobe,
  input wire logic ack,
  output logic [15:0] in_word,
  output logic req_a,
  output logic req_b
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] got = 16'h0000;
  logic [15:0] word = 16'h0000;
  logic strobe_d = 1'b0;
  logic ack_d = 1'b0;
  logic hold_a = 1'b0;
  logic hold_b = 1'b0;
  // raise only toggles these, so each request keeps one driver
  logic tog_a = 1'b0;
  logic tog_b = 1'b0;
  logic seen_a = 1'b0;
  logic seen_b = 1'b0;
  int n_got = 0;
  int n_ack = 0;
  assign in_word = word;
  assign req_a = hold_a;
  assign req_b = hold_b;
  always @(posedge clk) begin
    strobe_d <= strobe;
    ack_d <= ack;
    seen_a <= tog_a;
    seen_b <= tog_b;
    // capture on trailing edge, then drop request a
    if (strobe_d && !strobe) begin
      got <= out_word;
      n_got <= n_got + 1;
      hold_a <= 1'b0;
    end else if (tog_a != seen_a) begin
      hold_a <= 1'b1;
    end
    // acknowledge trailing edge drops request b
    if (ack_d && !ack) begin
      n_ack <= n_ack + 1;
      hold_b <= 1'b0;
    end else if (tog_b != seen_b) begin
      hold_b <= 1'b1;
    end
  end
  // word changes only when offered, held until the next put
  task automatic put(input logic [15:0] w);
    @(posedge clk);
    word <= w;
  endtask
  // request rises and stays until withdrawn
  task automatic raise(input logic a, input logic b);
    @(posedge clk);
    if (a) tog_a <= ~tog_a;
    if (b) tog_b <= ~tog_b;
  endtask
endmodule // plu_user

// ### sim/parallel_line_unit_tb.sv
/* self-checking bench for the parallel line unit.
   assumes factory jumpers and a host that runs one bus cycle at a time. */
`include "plu_regs.vh"

module parallel_line_unit_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] A_CSR = `PLU_DEF_ADDR;
  localparam logic [15:0] A_OUT = A_CSR + 16'h0002;
  localparam logic [15:0] A_IN = A_CSR + 16'h0004;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic binit_n = 1'b1;
  logic [15:0] bal = 16'h0000;
  logic bsync_n = 1'b1;
  logic bdin_n = 1'b1;
  logic bdout_n = 1'b1;
  logic bbs7_n = 1'b1;
  logic biaki_n = 1'b1;
  wire [15:0] bdal_out, user_in, user_out;
  wire rply, irq, strobe, ack, req_a, req_b, cmd0, cmd1, ini_a, ini_b;
  wire oe, iako_n;
  int n_fail = 0;
  int comparisons = 0;
  always #12.5 clk = ~clk;
  plu_top plu_top_i (.CORE_CLK(clk), .RST_N(rst_n), .BUS_INIT_N(binit_n), .BDAL_IN(bal), .BDAL_OUT(bdal_out),
    .BDAL_OE(oe), .BSYNC_N(bsync_n), .BDIN_N(bdin_n), .BDOUT_N(bdout_n), .BBS7_N(bbs7_n), .BIAKI_N(biaki_n),
    .BIAKO_N(iako_n), .BRPLY_OE(rply), .BIRQ_OE(irq), .ADDR_JUMPER(`PLU_DEF_ADDR_JMP), .VEC_JUMPER(`PLU_DEF_VEC_JMP),
    .USER_IN(user_in), .USER_OUT(user_out), .OUT_STROBE(strobe), .READ_ACK_PULSE(ack), .USER_REQ_A(req_a),
    .USER_REQ_B(req_b), .USER_CMD_0(cmd0), .USER_CMD_1(cmd1), .USER_RESET_OUT_A(ini_a), .USER_RESET_OUT_B(ini_b));
  plu_user plu_user_i (.clk(clk), .out_word(user_out), .strobe(strobe), .ack(ack), .in_word(user_in),
    .req_a(req_a), .req_b(req_b));
  task automatic wrap_up;
    if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk16({15'h0000, g}, {15'h0000, e});
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  // ----
  // host cycle: m 0 read, 1 write, 2 interrupt grant; rx is the expected reply
  // ----
  task automatic ac(input int m, input logic [15:0] a, input logic [15:0] x = 16'h0000,
    input logic [15:0] d = 16'h0000, input logic rx = 1'b1, input logic bs7 = 1'b1);
    logic [15:0] r;
    logic p;
    logic q;
    logic g;
    if (m != 2) begin
      @(posedge clk);
      bal <= a;
      bbs7_n <= !bs7;
      bsync_n <= 1'b0;
      idle(4);
    end
    @(posedge clk);
    bal <= d;
    bdout_n <= (m != 1);
    bdin_n <= (m == 1);
    biaki_n <= (m != 2);
    p = 1'b0;
    r = 16'h0000;
    // refused cycles simply run out this bound
    for (int k = 0; k < 100 && !p; k++) begin
      @(posedge clk);
      p = rply;
      r = bdal_out;
      q = oe;
      g = iako_n;
    end
    bdout_n <= 1'b1;
    bdin_n <= 1'b1;
    biaki_n <= 1'b1;
    for (int k = 0; k < 20 && rply; k++) @(posedge clk);
    bsync_n <= 1'b1;
    bbs7_n <= 1'b1;
    idle(3);
    chk1(p, rx);
    chk1(q, rx && m != 1);
    chk1(g, m != 2 || rx);
    if (m != 1 && rx) chk16(r, x);
  endtask
  initial begin
    idle(6000);
    n_fail++;
    wrap_up;
  end
  initial begin
    idle(8);
    rst_n <= 1'b1;
    @(posedge clk);
    ac(0, A_CSR);
    ac(0, A_OUT);
    ac(1, A_OUT, 16'h0000, 16'hA5C3);
    idle(20);
    chk16(plu_user_i.got, 16'hA5C3);
    chk16(user_out, 16'hA5C3);
    // back to back, but each word leaves the buffer before the next cycle, so the read does not wait
    for (int i = 0; i < 3; i++) ac(1, A_OUT, 16'h0000, 16'h0001 << (i * 7));
    ac(0, A_OUT, 16'h4000);
    idle(40);
    chk16(plu_user_i.got, 16'h4000);
    chk16(16'(plu_user_i.n_got), 16'h0004);
    plu_user_i.put(16'h3C5A);
    idle(4);
    ac(0, A_IN, 16'h3C5A);
    ac(1, A_IN, 16'h0000, 16'hFFFF);
    ac(0, A_IN, 16'h3C5A);
    idle(20);
    chk16(16'(plu_user_i.n_ack), 16'h0002);
    ac(1, A_CSR + 16'h0006, 16'h0000, 16'h1111, 1'b0);
    ac(0, A_CSR + 16'h0006, 16'h0000, 16'h0000, 1'b0);
    ac(1, A_OUT ^ 16'h1000, 16'h0000, 16'h1111, 1'b0);
    ac(1, A_OUT, 16'h0000, 16'h1111, 1'b0, 1'b0);
    ac(0, A_OUT, 16'h4000);
    ac(1, A_CSR, 16'h0000, 16'hFFFF);
    ac(0, A_CSR, 16'h0063);
    ac(1, A_CSR, 16'h0000, 16'h0002);
    ac(0, A_CSR, 16'h0002);
    chk16({14'h0000, cmd1, cmd0}, 16'h0002);
    ac(1, A_CSR, 16'h0000, 16'h0060);
    plu_user_i.raise(1'b1, 1'b1);
    idle(8);
    ac(0, A_CSR, 16'h80E0);
    chk1(irq, 1'b1);
    ac(2, 16'h0000, {8'h00, `PLU_DEF_VEC_A});
    idle(4);
    chk1(irq, 1'b1);
    ac(2, 16'h0000, {8'h00, `PLU_DEF_VEC_B});
    idle(4);
    chk1(irq, 1'b0);
    ac(2, 16'h0000, 16'h0000, 16'h0000, 1'b0);
    ac(1, A_OUT, 16'h0000, 16'h00FF);
    ac(0, A_IN, 16'h3C5A);
    idle(30);
    ac(0, A_CSR, 16'h0060);
    ac(1, A_CSR, 16'h0000, 16'h0020);
    plu_user_i.raise(1'b1, 1'b0);
    idle(8);
    chk1(irq, 1'b0);
    ac(1, A_CSR, 16'h0000, 16'h0060);
    idle(4);
    chk1(irq, 1'b1);
    ac(1, A_CSR, 16'h0000, 16'h0023);
    idle(4);
    chk1(irq, 1'b0);
    binit_n <= 1'b0;
    idle(6);
    chk16({14'h0000, ini_a, ini_b}, 16'h0003);
    binit_n <= 1'b1;
    idle(6);
    chk16({14'h0000, ini_a, ini_b}, 16'h0000);
    chk16(user_out, 16'h0000);
    ac(0, A_CSR, 16'h0080);
    wrap_up;
  end
endmodule // parallel_line_unit_tb
